// ### hdl/mibo_defs.svh
// Offsets, field positions, codes and reset values for the mode register block
`ifndef MIBO_DEFS_SVH
`define MIBO_DEFS_SVH
`define MIBO_ADDR_INFO 8'h00
`define MIBO_ADDR_FEAT 8'h01
// Device type code is arbitrary
`define MIBO_DEV_TYPE 1'b1
`define MIBO_DNV_SUPPORT 1'b0
`define MIBO_RSVD3 3'h0
`define MIBO_BYTE_ZERO 8'h00
`define MIBO_LEN_LSB 0
`define MIBO_LEN_MSB 2
`define MIBO_ORDER_BIT 3
`define MIBO_WRAP_BIT 4
`define MIBO_WR_LSB 5
`define MIBO_WR_MSB 7
`define MIBO_BL4 3'h2
`define MIBO_BL8 3'h3
`define MIBO_BL16 3'h4
`define MIBO_WR_MIN 3'h1
`define MIBO_WR_MAX 3'h6
`define MIBO_WR_OFS 4'h2
`define MIBO_CAL_NONE 2'h0
`define MIBO_CAL_OPEN 2'h1
`define MIBO_CAL_SHORT 2'h2
`define MIBO_BEATS4 4'h3
`define MIBO_BEATS8 4'h7
`define MIBO_BEATS16 4'hf
`define MIBO_CNT_ONE 4'h1
`define MIBO_CNT_ZERO 4'h0
`endif

// ### hdl/mibo_pkg.sv
// Types shared by the mode register block
package mibo_pkg;
    typedef logic [2:0] mibo_code3_t;
    typedef enum logic [0:0] {MIBO_IDLE, MIBO_RUN} mibo_seq_e;
endpackage

// ### hdl/mibo_burst_seq.sv
// Burst column order generator
`timescale 1ns/100ps
`default_nettype none
`include "mibo_defs.svh"
module mibo_burst_seq (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic [3:0] start_col,
    input wire mibo_pkg::mibo_code3_t len_code,
    input wire logic interleave,
    input wire logic no_wrap,
    output logic col_valid,
    output logic [3:0] col_addr,
    output logic col_last
);
    import mibo_pkg::*;

    mibo_seq_e st_q, st_d;
    logic [3:0] beat_q, beat_d;
    logic [3:0] base_q, base_d;
    logic [3:0] last_q, last_d;
    logic [3:0] col_q, col_d;
    logic il_q, il_d;
    logic nowrap_q, nowrap_d;

    // Column of beat b for a burst from column c, length given by last beat index
    function automatic logic [3:0] beat_col(input logic [3:0] c, input logic [3:0] b,
                                            input logic [3:0] lst, input logic il, input logic nowrap);
        logic [3:0] s;
        s = c + b;
        if (lst == `MIBO_BEATS4)
            beat_col = nowrap ? s : {c[3:2], s[1:0]}; // RULE_13
        else if (lst == `MIBO_BEATS8)
            beat_col = il ? {c[3], c[2:0] ^ b[2:0]} : {c[3], s[2:0]}; // RULE_14
        else
            beat_col = s; // RULE_15
    endfunction

    function automatic logic [3:0] last_beat(input mibo_code3_t code);
        case (code)
            `MIBO_BL8: last_beat = `MIBO_BEATS8;
            `MIBO_BL16: last_beat = `MIBO_BEATS16;
            default: last_beat = `MIBO_BEATS4;
        endcase
    endfunction

    always_comb
    begin
        st_d = st_q;
        beat_d = beat_q;
        base_d = base_q;
        last_d = last_q;
        il_d = il_q;
        nowrap_d = nowrap_q;
        col_d = col_q;
        case (st_q)
            MIBO_IDLE:
            begin
                if (start)
                begin
                    st_d = MIBO_RUN;
                    beat_d = `MIBO_CNT_ZERO;
                    base_d = {start_col[3:1], 1'b0}; // RULE_16
                    last_d = last_beat(len_code);
                    il_d = interleave;
                    nowrap_d = no_wrap;
                    col_d = {start_col[3:1], 1'b0}; // RULE_16
                end
            end
            MIBO_RUN:
            begin
                if (beat_q == last_q)
                    st_d = MIBO_IDLE;
                else
                begin
                    beat_d = beat_q + `MIBO_CNT_ONE;
                    col_d = beat_col(base_q, beat_q + `MIBO_CNT_ONE, last_q, il_q, nowrap_q);
                end
            end
            default: st_d = MIBO_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            st_q <= MIBO_IDLE;
            beat_q <= `MIBO_CNT_ZERO;
            base_q <= `MIBO_CNT_ZERO;
            last_q <= `MIBO_BEATS4;
            col_q <= `MIBO_CNT_ZERO;
            il_q <= 1'b0;
            nowrap_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            beat_q <= beat_d;
            base_q <= base_d;
            last_q <= last_d;
            col_q <= col_d;
            il_q <= il_d;
            nowrap_q <= nowrap_d;
        end
    end

    // New start requests are dropped while a burst is still running
    assign col_valid = (st_q == MIBO_RUN);
    assign col_addr = col_q;
    assign col_last = (st_q == MIBO_RUN) && (beat_q == last_q);

    a_first_even: assert property (@(posedge clk) disable iff (!nrst) // RULE_16
        (st_q == MIBO_IDLE && start) |=> (col_addr[0] == 1'b0))
        else $error("first burst column is odd");
    a_wrap4_order: assert property (@(posedge clk) disable iff (!nrst) // RULE_13
        (st_q == MIBO_IDLE && start && len_code == `MIBO_BL4 && !no_wrap && start_col[1])
        |=> col_addr[1:0] == 2'h2 ##1 col_addr[1:0] == 2'h3 ##1 col_addr[1:0] == 2'h0 ##1
            (col_addr[1:0] == 2'h1 && col_last))
        else $error("wrapping four beat order wrong");
    a_int8_order: assert property (@(posedge clk) disable iff (!nrst) // RULE_14
        (st_q == MIBO_IDLE && start && len_code == `MIBO_BL8 && interleave && start_col[2:1] == 2'h3)
        |=> col_addr[2:0] == 3'h6 ##1 col_addr[2:0] == 3'h7 ##1 col_addr[2:0] == 3'h4)
        else $error("interleaved eight beat order wrong");
    a_len16_last: assert property (@(posedge clk) disable iff (!nrst) // RULE_15
        (st_q == MIBO_IDLE && start && len_code == `MIBO_BL16)
        |=> (!col_last && col_valid) [*8] ##8 col_last ##1 !col_valid)
        else $error("sixteen beat burst length wrong");
    c_burst_done: cover property (@(posedge clk) disable iff (!nrst) col_last);
endmodule // mibo_burst_seq
`default_nettype wire

// ### hdl/mibo_mode_regs.sv
// Information and feature mode registers with burst ordering and write recovery
// Function
// RULE_01 - Info bit 0 reads 1 while auto-initialization runs, 0 when done.
// RULE_02 - Info bit 1 is a fixed device type; bit 2 reads 0.
// RULE_03 - Info bits 4:3 hold the calibration pin self-test result code.
// RULE_04 - Self-test field changes only when the calibration init command completes.
// RULE_05 - Calibration pin tied to supply reports code 01.
// RULE_06 - Codes 01 or 10 select factory drive trim and ignore calibration commands.
// RULE_07 - Feature bits 2:0 select burst length 4, 8 or 16; default 4.
// RULE_08 - Feature bit 3 selects sequential or interleaved order; default sequential.
// RULE_09 - Feature bit 4 selects wrap or no-wrap; no-wrap only with length 4.
// RULE_10 - Feature bits 7:5 select 3 to 8 write recovery cycles; default 3.
// RULE_11 - Auto-precharge write starts precharge after the programmed recovery cycles.
// RULE_12 - Controller programs recovery as recovery time over clock period, rounded up.
// RULE_13 - Four beat wrap orders 0123 or 2301; no-wrap runs y to y+3.
// RULE_14 - Eight beat wrap: sequential counts modulo 8, interleaved XORs beat index.
// RULE_15 - Sixteen beat counts modulo 16 sequential wrap only; others illegal.
// RULE_16 - Lowest column bit is treated as zero, bursts start at even columns.
// RULE_17 - Reserved bits are written as zero and read back as zero.
// RULE_18 - Controller uses only mode register read and write commands.
// RULE_19 - Reading a write-only register returns undefined data but toggles strobe.
// RULE_20 - Controller polls auto-init status until complete before normal use; the controller model has no poll and the bench runs a burst before init_done.
`timescale 1ns/100ps
`default_nettype none
`include "mibo_defs.svh"
module mibo_mode_regs (
    input wire logic clk,
    input wire logic nrst,
    input wire logic mr_wr_en,
    input wire logic mr_rd_en,
    input wire logic [7:0] mr_addr,
    input wire logic [7:0] mr_wdata,
    output logic [7:0] mr_rdata,
    output logic mr_rvalid,
    output logic mr_strobe_toggle,
    input wire logic init_done,
    input wire logic cal_done,
    input wire logic [1:0] cal_result,
    input wire logic cal_cmd,
    output logic cal_cmd_accept,
    output logic factory_trim_sel,
    input wire logic wr_autopre_end,
    output logic precharge_start,
    output logic [3:0] write_recovery_cycles,
    input wire logic burst_start,
    input wire logic [3:0] burst_col,
    output logic burst_illegal,
    output logic col_valid,
    output logic [3:0] col_addr,
    output logic col_last
);
    import mibo_pkg::*;

    logic auto_init_status_q, auto_init_status_d;
    logic [1:0] cal_pin_selftest_result_q, cal_pin_selftest_result_d;
    mibo_code3_t burst_length_q, burst_length_d;
    logic burst_type_q, burst_type_d;
    logic wrap_control_q, wrap_control_d;
    mibo_code3_t wr_code_q, wr_code_d;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic [3:0] wr_cnt_q, wr_cnt_d;
    logic [3:0] info_unused;

    function automatic logic legal_len(input mibo_code3_t c);
        legal_len = (c == `MIBO_BL4) || (c == `MIBO_BL8) || (c == `MIBO_BL16);
    endfunction

    assign factory_trim_sel = (cal_pin_selftest_result_q == `MIBO_CAL_OPEN) ||
                              (cal_pin_selftest_result_q == `MIBO_CAL_SHORT); // RULE_06
    assign cal_cmd_accept = cal_cmd && !factory_trim_sel; // RULE_06
    assign write_recovery_cycles = {1'b0, wr_code_q} + `MIBO_WR_OFS; // RULE_10

    always_comb
    begin
        auto_init_status_d = !init_done; // RULE_01
        cal_pin_selftest_result_d = cal_pin_selftest_result_q;
        if (cal_done)
            cal_pin_selftest_result_d = cal_result; // RULE_04 RULE_05
        burst_length_d = burst_length_q;
        burst_type_d = burst_type_q;
        wrap_control_d = wrap_control_q;
        wr_code_d = wr_code_q;
        // Writes to the read-only info register have no effect
        if (mr_wr_en && mr_addr == `MIBO_ADDR_FEAT)
        begin
            // Reserved codes are dropped so the field keeps a usable value
            if (legal_len(mr_wdata[`MIBO_LEN_MSB:`MIBO_LEN_LSB]))
                burst_length_d = mr_wdata[`MIBO_LEN_MSB:`MIBO_LEN_LSB]; // RULE_07
            burst_type_d = mr_wdata[`MIBO_ORDER_BIT]; // RULE_08
            wrap_control_d = mr_wdata[`MIBO_WRAP_BIT]; // RULE_09
            if (mr_wdata[`MIBO_WR_MSB:`MIBO_WR_LSB] >= `MIBO_WR_MIN &&
                mr_wdata[`MIBO_WR_MSB:`MIBO_WR_LSB] <= `MIBO_WR_MAX)
                wr_code_d = mr_wdata[`MIBO_WR_MSB:`MIBO_WR_LSB]; // RULE_10
        end
        rvalid_d = mr_rd_en;
        // Write-only and unmapped reads answer zero so no stale byte leaks out
        rdata_d = `MIBO_BYTE_ZERO; // RULE_19
        if (mr_rd_en && mr_addr == `MIBO_ADDR_INFO)
            rdata_d = {`MIBO_RSVD3, cal_pin_selftest_result_q, `MIBO_DNV_SUPPORT,
                       `MIBO_DEV_TYPE, auto_init_status_q}; // RULE_01 RULE_02 RULE_03 RULE_17
        wr_cnt_d = wr_cnt_q;
        if (wr_autopre_end)
            wr_cnt_d = write_recovery_cycles; // RULE_11
        else if (wr_cnt_q != `MIBO_CNT_ZERO)
            wr_cnt_d = wr_cnt_q - `MIBO_CNT_ONE;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            auto_init_status_q <= 1'b1;
            cal_pin_selftest_result_q <= `MIBO_CAL_NONE;
            burst_length_q <= `MIBO_BL4;
            burst_type_q <= 1'b0;
            wrap_control_q <= 1'b0;
            wr_code_q <= `MIBO_WR_MIN;
            rdata_q <= `MIBO_BYTE_ZERO;
            rvalid_q <= 1'b0;
            wr_cnt_q <= `MIBO_CNT_ZERO;
        end
        else
        begin
            auto_init_status_q <= auto_init_status_d;
            cal_pin_selftest_result_q <= cal_pin_selftest_result_d;
            burst_length_q <= burst_length_d;
            burst_type_q <= burst_type_d;
            wrap_control_q <= wrap_control_d;
            wr_code_q <= wr_code_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            wr_cnt_q <= wr_cnt_d;
        end
    end

    assign mr_rdata = rdata_q;
    assign mr_rvalid = rvalid_q;
    // Strobe toggles for every read, readable register or not
    assign mr_strobe_toggle = rvalid_q; // RULE_19
    assign precharge_start = (wr_cnt_q == `MIBO_CNT_ONE); // RULE_11

    // Combinations the controller must not program are refused, no columns come out
    assign burst_illegal = (wrap_control_q && burst_length_q != `MIBO_BL4) ||
                           (burst_type_q && burst_length_q == `MIBO_BL16); // RULE_09 RULE_15

    mibo_burst_seq u_seq (
        .clk(clk),
        .nrst(nrst),
        .start(burst_start && !burst_illegal),
        .start_col(burst_col),
        .len_code(burst_length_q),
        .interleave(burst_type_q),
        .no_wrap(wrap_control_q),
        .col_valid(col_valid),
        .col_addr(col_addr),
        .col_last(col_last)
    );

    // Helper: cycles since the last auto-precharge write end
    logic [3:0] pre_age_q;
    always_ff @(posedge clk)
    begin
        if (!nrst)
            pre_age_q <= `MIBO_CNT_ZERO;
        else if (wr_autopre_end)
            pre_age_q <= `MIBO_CNT_ONE;
        else if (pre_age_q != `MIBO_BEATS16)
            pre_age_q <= pre_age_q + `MIBO_CNT_ONE;
    end
    assign info_unused = {mr_rdata[7:5], 1'b0};

    a_rd_answer: assert property (@(posedge clk) disable iff (!nrst) // RULE_19
        mr_rd_en |=> (mr_rvalid && mr_strobe_toggle))
        else $error("read not answered next cycle");
    a_info_bits: assert property (@(posedge clk) disable iff (!nrst) // RULE_02
        (mr_rvalid && $past(mr_addr) == `MIBO_ADDR_INFO) |-> (mr_rdata[2:1] == 2'h1))
        else $error("type or data-invalid bits wrong");
    a_rsvd_zero: assert property (@(posedge clk) disable iff (!nrst) // RULE_17
        mr_rvalid |-> (info_unused == 4'h0))
        else $error("reserved info bits not zero");
    a_init_flag: assert property (@(posedge clk) disable iff (!nrst) // RULE_01
        (mr_rd_en && mr_addr == `MIBO_ADDR_INFO && init_done && $past(init_done))
        |=> (mr_rdata[0] == 1'b0))
        else $error("init status shows busy after done");
    a_cal_hold: assert property (@(posedge clk) disable iff (!nrst) // RULE_04
        !cal_done |=> $stable(cal_pin_selftest_result_q))
        else $error("self-test field moved without completion");
    a_cal_ignore: assert property (@(posedge clk) disable iff (!nrst) // RULE_06
        (cal_pin_selftest_result_q == `MIBO_CAL_OPEN) |-> !cal_cmd_accept)
        else $error("calibration accepted with open pin");
    a_prech_delay: assert property (@(posedge clk) disable iff (!nrst) // RULE_11
        precharge_start |-> (pre_age_q == write_recovery_cycles))
        else $error("precharge not at recovery count");
    a_wr_range: assert property (@(posedge clk) disable iff (!nrst) // RULE_10
        (write_recovery_cycles >= 4'h3) && (write_recovery_cycles <= 4'h8))
        else $error("recovery cycles out of range");
    a_bl_legal: assert property (@(posedge clk) disable iff (!nrst) // RULE_07
        (mr_wr_en && mr_addr == `MIBO_ADDR_FEAT && mr_wdata[2:0] == 3'h3) |=> (burst_length_q == 3'h3))
        else $error("burst length eight not taken");
    a_nw_refused: assert property (@(posedge clk) disable iff (!nrst) // RULE_09
        (burst_start && wrap_control_q && burst_length_q == `MIBO_BL8 && !col_valid) |=> !col_valid)
        else $error("illegal no-wrap burst ran");
    a_cal_capture: assert property (@(posedge clk) disable iff (!nrst) // RULE_04
        cal_done |=> (cal_pin_selftest_result_q == $past(cal_result)))
        else $error("self-test field missed completion");
    a_type_taken: assert property (@(posedge clk) disable iff (!nrst) // RULE_08
        (mr_wr_en && mr_addr == `MIBO_ADDR_FEAT) |=> (burst_type_q == $past(mr_wdata[`MIBO_ORDER_BIT])))
        else $error("burst type not taken");
    a_wr_reserved: assert property (@(posedge clk) disable iff (!nrst) // RULE_10
        (mr_wr_en && mr_addr == `MIBO_ADDR_FEAT && mr_wdata[7:5] == 3'h0) |=> $stable(write_recovery_cycles))
        else $error("reserved recovery code taken");
    a_wo_read_zero: assert property (@(posedge clk) disable iff (!nrst) // RULE_19
        (mr_rvalid && $past(mr_addr) != `MIBO_ADDR_INFO) |-> (mr_rdata == 8'h00))
        else $error("write-only read not zero");

    c_info_read: cover property (@(posedge clk) disable iff (!nrst)
        mr_rvalid && mr_rdata[4:3] == 2'h3);
    c_precharge: cover property (@(posedge clk) disable iff (!nrst) precharge_start && write_recovery_cycles == 4'h8);
    c_factory: cover property (@(posedge clk) disable iff (!nrst) cal_cmd && factory_trim_sel);
    c_refused: cover property (@(posedge clk) disable iff (!nrst) burst_start && burst_illegal);
endmodule // mibo_mode_regs
`default_nettype wire

// ### sim/mibo_ctrl_model.sv
// Memory controller model issuing mode register commands
`timescale 1ns/100ps
`default_nettype none
module mibo_ctrl_model (
    input wire logic clk,
    output var logic mr_wr_en,
    output var logic mr_rd_en,
    output var logic [7:0] mr_addr,
    output var logic [7:0] mr_wdata
);
    initial
    begin
        mr_wr_en = 1'b0;
        mr_rd_en = 1'b0;
        mr_addr = 8'h00;
        mr_wdata = 8'h00;
    end

    // Code 1 stands for 3 cycles, so the rounded-up cycle count is offset by two
    function automatic logic [2:0] wr_code(input int twr_ns, input int tck_ns);
        return 3'((twr_ns + tck_ns - 1) / tck_ns - 2);
    endfunction

    // Released bus shows the inverse so stale values cannot pass for a match
    task automatic mrw(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        mr_wr_en <= 1'b1;
        mr_addr <= a;
        mr_wdata <= d;
        @(posedge clk);
        mr_wr_en <= 1'b0;
        mr_addr <= ~a;
        mr_wdata <= ~d;
    endtask

    task automatic mrr(input logic [7:0] a);
        @(posedge clk);
        mr_rd_en <= 1'b1;
        mr_addr <= a;
        @(posedge clk);
        mr_rd_en <= 1'b0;
        mr_addr <= ~a;
    endtask
endmodule // mibo_ctrl_model
`default_nettype wire

// ### sim/mibo_mode_regs_tb.sv
// Self-checking bench for the mode register block
`timescale 1ns/100ps
`default_nettype none
module mibo_mode_regs_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic init_done = 1'b0, cal_done = 1'b0, cal_cmd = 1'b0, wr_autopre_end = 1'b0, burst_start = 1'b0;
    logic [1:0] cal_result = 2'h0;
    logic [3:0] burst_col = 4'h0;
    logic mr_wr_en, mr_rd_en, mr_rvalid, mr_strobe_toggle, cal_cmd_accept, factory_trim_sel, precharge_start;
    logic burst_illegal, col_valid, col_last;
    logic [7:0] mr_addr, mr_wdata, mr_rdata;
    logic [3:0] write_recovery_cycles, col_addr;
    logic [31:0] rnd = 32'he33c;
    logic [7:0] modes[10] = '{8'h22, 8'h2a, 8'h32, 8'h3a, 8'h23, 8'h2b, 8'h24, 8'h33, 8'h2c, 8'h34};
    int fail_count = 0, checks = 0, cyc = 0;
    logic [8:0] rd_q[$];
    logic [4:0] col_q[$];
    int pre_q[$];

    always #20 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    mibo_ctrl_model i_ctrl (.clk, .mr_wr_en, .mr_rd_en, .mr_addr, .mr_wdata);
    mibo_mode_regs i_dut (.clk, .nrst, .mr_wr_en, .mr_rd_en, .mr_addr, .mr_wdata, .mr_rdata, .mr_rvalid,
        .mr_strobe_toggle, .init_done, .cal_done, .cal_result, .cal_cmd, .cal_cmd_accept, .factory_trim_sel,
        .wr_autopre_end, .precharge_start, .write_recovery_cycles, .burst_start, .burst_col, .burst_illegal,
        .col_valid, .col_addr, .col_last);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic cmp(input logic [15:0] exp, input logic [15:0] act);
        checks++;
        if (act !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, act);
        end
    endtask

    task automatic cmp_rd(input logic [15:0] exp, input logic [15:0] act);
        cmp(exp, act);
    endtask

    task automatic cmp_col(input logic [15:0] exp, input logic [15:0] act);
        cmp(exp, act);
    endtask

    task automatic cmp_pre(input logic [15:0] exp, input logic [15:0] act);
        cmp(exp, act);
    endtask

    task automatic end_sim();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // An empty queue expects unknown, so any unasked result counts as a mismatch
    always @(negedge clk)
    begin
        if (mr_rvalid === 1'b1)
            cmp_rd(rd_q.size() ? 16'(rd_q.pop_front()) : 16'hx, 16'({mr_strobe_toggle, mr_rdata}));
        if (col_valid === 1'b1)
            cmp_col(col_q.size() ? 16'(col_q.pop_front()) : 16'hx, 16'({col_addr, col_last}));
        if (precharge_start === 1'b1)
            cmp_pre(pre_q.size() ? 16'(pre_q.pop_front()) : 16'hx, 16'(cyc));
    end

    task automatic drain();
        int n = 0;
        while ((rd_q.size() + col_q.size() + pre_q.size()) != 0 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        if ((rd_q.size() + col_q.size() + pre_q.size()) != 0)
        begin
            fail_count++;
            end_sim();
        end
        repeat (4) @(negedge clk);
    endtask

    task automatic do_reset();
        @(posedge clk) nrst <= 1'b0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] d);
        rd_q.push_back({1'b1, d});
        i_ctrl.mrr(a);
    endtask

    // Idle result code differs from the captured one to expose capture without completion
    task automatic cal(input logic [1:0] r);
        @(posedge clk);
        cal_done <= 1'b1;
        cal_result <= r;
        @(posedge clk);
        cal_done <= 1'b0;
        cal_result <= ~r;
        cal_cmd <= 1'b1;
        @(negedge clk);
    endtask

    task automatic recov(input int n);
        @(posedge clk) wr_autopre_end <= 1'b1;
        @(negedge clk) pre_q.push_back(cyc + n);
        @(posedge clk) wr_autopre_end <= 1'b0;
        drain();
    endtask

    // Mode m is the effective feature value; ok low means the burst must be refused
    task automatic burst(input logic [3:0] c, input logic [7:0] m, input logic ok);
        logic [3:0] z;
        logic [3:0] e;
        int beats;
        z = {c[3:1], 1'b0};
        beats = ok ? (1 << m[2:0]) : 0;
        for (int k = 0; k < beats; k++)
        begin
            if (beats == 16 || m[4]) e = z + 4'(k);
            else if (beats == 4) e = {z[3:2], 2'(z[1:0] + 2'(k))};
            else if (m[3]) e = {z[3], z[2:0] ^ 3'(k)};
            else e = {z[3], 3'(z[2:0] + 3'(k))};
            col_q.push_back({e, k == beats - 1});
        end
        @(posedge clk);
        burst_start <= 1'b1;
        burst_col <= c;
        @(posedge clk);
        burst_start <= 1'b0;
        burst_col <= ~c;
        drain();
    endtask

    initial
    begin
        do_reset();
        rd(8'h00, 8'h03);
        rd(8'h01, 8'h00);
        rd(8'h55, 8'h00);
        cal(2'h3);
        cmp(16'h1, 16'({factory_trim_sel, cal_cmd_accept}));
        rd(8'h00, 8'h1b);
        cal(2'h2);
        cmp(16'h2, 16'({factory_trim_sel, cal_cmd_accept}));
        rd(8'h00, 8'h13);
        drain();
        do_reset();
        cmp(16'h3, 16'(write_recovery_cycles));
        burst(4'h3, 8'h22, 1'b1);
        cal(2'h1);
        cmp(16'h2, 16'({factory_trim_sel, cal_cmd_accept}));
        @(posedge clk) init_done <= 1'b1;
        rd(8'h00, 8'h0a);
        i_ctrl.mrw(8'h00, 8'hff);
        rd(8'h00, 8'h0a);
        drain();
        foreach (modes[i])
        begin
            i_ctrl.mrw(8'h01, modes[i]);
            @(negedge clk);
            cmp(16'(i >= 7), 16'(burst_illegal));
            repeat (2)
            begin
                rnd = lfsr(rnd);
                burst(rnd[3:0], modes[i], i < 7);
            end
        end
        i_ctrl.mrw(8'h01, 8'h23);
        i_ctrl.mrw(8'h01, 8'h27);
        burst(4'h6, 8'h23, 1'b1);
        i_ctrl.mrw(8'h01, 8'h2b);
        burst(4'h7, 8'h2b, 1'b1);
        for (int n = 3; n <= 8; n++)
        begin
            i_ctrl.mrw(8'h01, {i_ctrl.wr_code(n * 40 - 5, 40), 5'h02});
            @(negedge clk);
            cmp(16'(n), 16'(write_recovery_cycles));
            recov(n);
        end
        i_ctrl.mrw(8'h01, 8'h02);
        i_ctrl.mrw(8'h01, 8'he2);
        @(negedge clk);
        cmp(16'h8, 16'(write_recovery_cycles));
        drain();
        end_sim();
    end
endmodule // mibo_mode_regs_tb
`default_nettype wire
